// ---- dv/dphb_ref_model.sv ----
// Purpose: Reference clock sources seen by the holdover block.
// Assumes: Each source runs only while its run bit is high.
// Notes: A stopped source parks low, as an idle clock pin would.
`timescale 1ns/1ps
`default_nettype none
module dphb_ref_model #(
  parameter real HALF_NS = 370.0
) (
  input wire logic [1:0] run_i,
  output var logic [1:0] ref_o
);
  // Source 0's period is not a multiple of the core clock, so its edges drift in phase.
  for (genvar i = 0; i < 2; i++) begin : g_src
    initial ref_o[i] = 1'b0;
    always begin
      #(HALF_NS + 30.0 * i);
      ref_o[i] = run_i[i] ? ~ref_o[i] : 1'b0;
    end
  end
endmodule : dphb_ref_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the holdover, bandwidth and divider block.
// Assumes: Shortened history and average steps; loop words driven by the bench.
// Notes: Every scenario task drives the block and judges its answers itself.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dphb_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  dphb_wb_req_t req = '0;
  dphb_wb_rsp_t rsp;
  logic [1:0] run = 2'b00;
  logic [1:0] refs;
  logic [FW-1:0] lfreq = 16'h9000;
  logic lock_det = 1'b1;
  logic [FW-1:0] freq;
  logic track;
  logic hold;
  logic intout;
  logic [3:0] bw;
  logic [1:0] loss;
  logic [31:0] rd;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #20 clk_i = ~clk_i;
  dphb_ref_model refm (.run_i(run), .ref_o(refs));
  dphb_core #(.HIST_STEP(16), .IIR_STEP(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .ref_i(refs),
    .loop_freq_i(lfreq), .lock_det_i(lock_det), .freq_ctl_o(freq), .track_en_o(track),
    .bw_code_o(bw), .holdover_o(hold), .signal_loss_flag_o(loss), .integer_output_o(intout)
  );
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // A hung wait lands here instead of running forever.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
    @(posedge clk_i);
  endtask : wb
  task automatic wait_loss(input logic v);
    while (loss[0] !== v) @(posedge clk_i);
  endtask : wait_loss
  task automatic s_reset();
    logic [7:0] adr [5] = '{ADR_CTRL, ADR_BW, ADR_MON, ADR_DIV, 8'h18};
    logic [31:0] exp [5] = '{32'h0, 32'h0, MON_RST, 32'h0, 32'h0};
    chk({bw, loss, hold, freq}, {4'hF, 2'b11, 1'b0, FREQ_CENTRE});
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, adr[i], 32'h0, rd);
      chk(rd, exp[i]);
    end
  endtask : s_reset
  task automatic s_lock(input logic [1:0] mode, input logic gap);
    int n;
    logic [31:0] want;
    n = 0;
    want = (mode == HM_CENTRE) ? 32'h8000 : (mode == HM_INST) ? 32'h9000 : 32'h9100;
    // A holdover-seen flag left by the previous call would still read back set in the status check.
    wait_loss(1'b1);
    wb(1'b1, ADR_STAT, 32'h0000_0002, rd);
    wb(1'b1, ADR_CTRL, (32'(mode) << 4) | (32'(gap) << 6) | 32'h0000_0300, rd);
    lfreq <= 16'h9000;
    run <= 2'b01;
    wait_loss(1'b0);
    repeat (8) @(posedge clk_i);
    chk({30'h0, loss}, 32'h2);
    chk({15'h0, hold, freq}, 32'h0000_9000);
    chk(32'(track), 32'h1);
    wb(1'b0, ADR_STAT, 32'h0, rd);
    chk({29'h0, rd[2:0]}, 32'h4);
    run <= 2'b00;
    while (hold !== 1'b1) begin
      @(posedge clk_i);
      n++;
      // A late step sets the last loop value apart from the older history samples.
      if (n == 100) lfreq <= 16'h9100;
    end
    chk(32'(gap ? n > 200 : n < 200), 32'h1);
    lfreq <= 16'h7000;
    @(posedge clk_i);
    chk(32'(freq), want);
    repeat (20) @(posedge clk_i);
    if (mode != HM_FAST) begin
      chk(32'(freq), want);
    end else begin
      repeat (280) @(posedge clk_i);
      chk(32'(freq == 16'h90F8 || freq == 16'h90F0), 32'h1);
    end
    chk(32'(track), 32'h0);
    wb(1'b0, ADR_STAT, 32'h0, rd);
    chk({30'h0, rd[1:0]}, 32'h3);
  endtask : s_lock
  task automatic s_bw();
    run <= 2'b01;
    wait_loss(1'b0);
    wb(1'b1, ADR_BW, 32'h0000_0093, rd);
    wb(1'b1, ADR_CTRL, 32'h0000_0008, rd);
    lock_det <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(32'(bw), 32'h3);
    lock_det <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(32'(bw), 32'h9);
    wb(1'b1, ADR_CTRL, 32'h0000_0000, rd);
    lock_det <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(32'(bw), 32'h9);
    wb(1'b1, ADR_BW, 32'h0000_00F0, rd);
    repeat (4) @(posedge clk_i);
    chk(32'(bw), 32'hE);
    wb(1'b1, ADR_CTRL, 32'h0000_0007, rd);
    repeat (4) @(posedge clk_i);
    chk({bw, hold, freq}, {4'hF, 1'b0, FREQ_CENTRE});
    wb(1'b1, ADR_CTRL, 32'h0000_0000, rd);
    lock_det <= 1'b1;
    run <= 2'b00;
  endtask : s_bw
  task automatic s_div();
    logic [31:0] dv [4] = '{32'h0, 32'h2, 32'h5, 32'hB};
    int ex [4] = '{4, 6, 10, 16};
    realtime t;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ADR_DIV, dv[i], rd);
      wb(1'b1, ADR_CTRL, 32'h0000_0080, rd);
      @(posedge intout);
      t = $realtime;
      @(posedge intout);
      chk(32'(int'(($realtime - t) / 40.0)), 32'(ex[i]));
    end
  endtask : s_div
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset();
    s_lock(HM_CENTRE, 1'b0);
    s_lock(HM_INST, 1'b0);
    s_lock(HM_FAST, 1'b1);
    s_bw();
    s_div();
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// ---- logic/dphb_core.sv ----
// Purpose: Holdover decision, loop bandwidth selection and two-stage integer divider.
// Assumes: ref_i are asynchronous pins; loop_freq_i and lock_det_i come from the loop.
// Notes: The divider runs on clk_i itself as a stand-in for the loop output clock.
// Behaviour
// [R1] Gapped mode: holdover only after two expired monitor periods.
// [R2] Gapped mode keeps tracking through gaps shorter than the period.
// [R3] No valid reference left means the loop goes into holdover.
// [R4] Fast average: hold last offset, then slew to the average.
// [R5] Centre option returns frequency to mid tuning range.
// [R6] Instantaneous option uses the frequency from 100 ms earlier.
// [R7] Fast average comes from an IIR with a 20 minute corner.
// [R8] Holdover entry sets a readable holdover flag.
// [R9] In holdover no free-run drift is detected or signalled.
// [R10] Synth select plus free-run code runs from the crystal alone.
// [R11] Synthesizer operation forces the fixed wide bandwidth.
// [R12] Otherwise fifteen bandwidth codes are selectable.
// [R13] Acquisition bandwidth applies until lock, then locked bandwidth.
// [R14] Acquisition disabled means locked bandwidth always.
// [R15] Integer divider is two cascaded stages, ratio is the product.
// [R16] First stage divides by four, five or six only.
// [R17] Second stage bypasses or divides by even ratios 2 to 131070; the code takes even ratios up to 262142.
// [R18] Software issues a sync trigger after divider changes.
// [R19] Monitor ticks at the oscillator rate divided by eight.
// [R20] One expiry raises a soft alarm, a second declares signal loss.
// [R21] Loss clears after eight edges; an error restarts the count.
// [R22] A validated reference moves the loop to the locked state.
// [R23] Holdover and bandwidth codes are one per listed option.
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module dphb_core
  import dphb_pkg::*;
#(
  parameter int HIST_STEP = HIST_STEP_CYC,
  parameter int IIR_STEP = IIR_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dphb_wb_req_t wb_req_i,
  output dphb_wb_rsp_t wb_rsp_o,
  input wire logic [1:0] ref_i,
  input wire logic [FW-1:0] loop_freq_i,
  input wire logic lock_det_i,
  output logic [FW-1:0] freq_ctl_o,
  output logic track_en_o,
  output logic [3:0] bw_code_o,
  output logic holdover_o,
  output logic [1:0] signal_loss_flag_o,
  output logic integer_output_o
);
  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i+:8] = n[8*i+:8];
    end
    return r;
  endfunction : wmask

  function automatic logic [3:0] bw_clamp(input logic [3:0] c);
    return (c > BW_MAX) ? BW_MAX : c; // R12 R23
  endfunction : bw_clamp

  function automatic logic [2:0] ratio1(input logic [1:0] c);
    case (c)
      2'h1: return 3'h5;
      2'h2: return 3'h6;
      default: return 3'h4; // R16
    endcase
  endfunction : ratio1

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Register bus.
  logic ack_q;
  logic [31:0] dat_q, ctrl_q, bw_q, mon_q, div_q;
  logic sync_q, hseen_q;
  wire req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  wire wr = req & wb_req_i.we;
  wire hit_ctrl = wb_req_i.adr == ADR_CTRL;
  wire hit_bw = wb_req_i.adr == ADR_BW;
  wire hit_mon = wb_req_i.adr == ADR_MON;
  wire hit_div = wb_req_i.adr == ADR_DIV;
  wire hit_stat = wb_req_i.adr == ADR_STAT;
  wire hit_hf = wb_req_i.adr == ADR_HFREQ;
  wire clr_hseen = wr & hit_stat & wb_req_i.sel[0] & wb_req_i.dat[S_HSEEN];
  wire synth_on = ctrl_q[C_SYNTH] & (ctrl_q[C_STATE+:2] == STATE_FREERUN); // R10
  wire acq_en = ctrl_q[C_ACQ];
  wire [1:0] hmode = ctrl_q[C_HMODE+:2];
  wire gap_en = ctrl_q[C_GAP];
  wire [1:0] slew = ctrl_q[C_SLEW+:2];
  logic [31:0] stat_w, hf_w, rd_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      ctrl_q <= 32'h0000_0000;
      bw_q <= 32'h0000_0000;
      mon_q <= MON_RST;
      div_q <= 32'h0000_0000;
      sync_q <= 1'b0;
    end else begin
      ack_q <= req;
      if (req) dat_q <= rd_w;
      if (wr && hit_ctrl) ctrl_q <= wmask(ctrl_q, wb_req_i.dat, wb_req_i.sel) & CTRL_MASK;
      if (wr && hit_bw) bw_q <= wmask(bw_q, wb_req_i.dat, wb_req_i.sel) & BW_MASK;
      if (wr && hit_mon) mon_q <= wmask(mon_q, wb_req_i.dat, wb_req_i.sel) & MON_MASK;
      if (wr && hit_div) div_q <= wmask(div_q, wb_req_i.dat, wb_req_i.sel) & DIV_MASK;
      sync_q <= wr & hit_ctrl & wb_req_i.sel[0] & wb_req_i.dat[C_SYNC]; // R18
    end
  end
  assign rd_w = hit_ctrl ? ctrl_q : hit_bw ? bw_q : hit_mon ? mon_q : hit_div ? div_q :
                hit_stat ? stat_w : hit_hf ? hf_w : 32'h0000_0000;
  assign wb_rsp_o = '{ack: ack_q, dat: dat_q};

  // Monitor clock enable.
  logic [2:0] mdiv_q;
  wire mon_tick = mdiv_q == 3'(MON_DIV - 1); // R19
  always_ff @(posedge clk_i) begin
    if (rst_i) mdiv_q <= 3'h0;
    else mdiv_q <= mdiv_q + 3'h1;
  end

  // Input activity monitors.
  logic [1:0] sa_q, sb_q, sc_q, soft_q, loss_q, valid;
  logic [16:0] mcnt_q [2];
  logic [2:0] vcnt_q [2];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sa_q <= 2'h0;
      sb_q <= 2'h0;
      sc_q <= 2'h0;
    end else begin
      sa_q <= ref_i;
      sb_q <= sa_q;
      sc_q <= sb_q;
    end
  end
  wire [1:0] edge_w = sb_q & ~sc_q;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_mon
      wire expire = mon_tick & ({1'b0, mcnt_q[g]} + 18'h1 >= {1'b0, mon_q[16:0]});
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mcnt_q[g] <= 17'h0;
          vcnt_q[g] <= 3'h0;
          soft_q[g] <= 1'b0;
          loss_q[g] <= 1'b1;
        end else if (edge_w[g]) begin
          mcnt_q[g] <= 17'h0;
          soft_q[g] <= 1'b0;
          if (loss_q[g]) begin
            vcnt_q[g] <= vcnt_q[g] + 3'h1;
            if (vcnt_q[g] == VALID_LAST) loss_q[g] <= 1'b0; // R21
          end
        end else if (expire) begin
          mcnt_q[g] <= 17'h0;
          soft_q[g] <= 1'b1; // R20
          if (soft_q[g] || loss_q[g]) begin
            loss_q[g] <= 1'b1; // R20
            vcnt_q[g] <= 3'h0; // R21
          end
        end else if (mon_tick) begin
          mcnt_q[g] <= mcnt_q[g] + 17'h1;
        end
      end
      // Without gap support a single missed period already counts against the input.
      assign valid[g] = ~loss_q[g] & ~(soft_q[g] & ~gap_en); // R1
      a_loss_second: assert property (soft_q[g] && !edge_w[g] && expire |=> loss_q[g]) // R20
        else $error("second expiry did not declare loss");
      a_valid_eight: assert property ($fell(loss_q[g]) |-> $past(vcnt_q[g]) == VALID_LAST) // R21
        else $error("loss cleared before eight edges");
    end
  endgenerate
  assign signal_loss_flag_o = loss_q;

  // Loop state.
  dphb_state_t state_q, state_d;
  wire any_valid = |valid;
  wire ref_sel = ~valid[0];
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_FREE: if (!synth_on && any_valid) state_d = ST_LOCK; // R22
      ST_LOCK: begin
        if (synth_on) state_d = ST_FREE;
        else if (!any_valid) state_d = ST_HOLD; // R3
      end
      ST_HOLD: begin
        if (synth_on) state_d = ST_FREE;
        else if (any_valid) state_d = ST_LOCK; // R22
      end
      default: state_d = ST_FREE;
    endcase
  end
  wire hold_enter = state_q != ST_HOLD && state_d == ST_HOLD;

  // Frequency history and averaging.
  logic [FW-1:0] hist_q [HIST_DEPTH];
  logic [1:0] hp_q;
  logic [19:0] hc_q;
  logic [16:0] ic_q;
  logic [7:0] sc_cnt_q;
  logic [FW+IIR_SHIFT-1:0] avg_q;
  logic [FW-1:0] hold_q, freq_q;
  logic [3:0] bwo_q;
  logic trk_q;
  wire hist_tick = hc_q == 20'(HIST_STEP - 1);
  wire iir_tick = ic_q == 17'(IIR_STEP - 1);
  wire slew_tick = sc_cnt_q == 8'(SLEW_STEP_CYC - 1);
  wire [FW-1:0] hist_old = hist_q[hp_q];
  wire [FW-1:0] avg_hi = avg_q[FW+IIR_SHIFT-1:IIR_SHIFT];
  wire signed [FW+IIR_SHIFT:0] avg_diff = $signed({1'b0, loop_freq_i, 16'h0000}) -
                                          $signed({1'b0, avg_q});
  wire [FW-1:0] step = FW'(1) << slew;
  wire [3:0] bw_sel = (acq_en && !lock_det_i) ? bw_clamp(bw_q[3:0]) : bw_clamp(bw_q[7:4]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_FREE;
      for (int i = 0; i < HIST_DEPTH; i++) hist_q[i] <= FREQ_CENTRE;
      hp_q <= 2'h0;
      hc_q <= 20'h0;
      ic_q <= 17'h0;
      sc_cnt_q <= 8'h00;
      avg_q <= {FREQ_CENTRE, 16'h0000};
      hold_q <= FREQ_CENTRE;
      hseen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hc_q <= hist_tick ? 20'h0 : hc_q + 20'h1;
      ic_q <= iir_tick ? 17'h0 : ic_q + 17'h1;
      sc_cnt_q <= slew_tick ? 8'h00 : sc_cnt_q + 8'h01;
      // History only learns while locked, so holdover never averages its own output.
      if (hist_tick && state_q == ST_LOCK) begin
        hist_q[hp_q] <= loop_freq_i; // R6
        hp_q <= hp_q + 2'h1;
      end
      if (iir_tick && state_q == ST_LOCK) begin
        avg_q <= avg_q + (FW+IIR_SHIFT)'(avg_diff >>> IIR_SHIFT); // R7
      end
      hseen_q <= hold_enter | (hseen_q & ~clr_hseen); // R8
      if (hold_enter) begin
        case (hmode)
          HM_INST: hold_q <= hist_old; // R6
          HM_FAST: hold_q <= loop_freq_i; // R4
          default: hold_q <= FREQ_CENTRE; // R5
        endcase
      end else if (state_q == ST_HOLD && hmode == HM_FAST && slew_tick) begin
        if (hold_q < avg_hi) hold_q <= (avg_hi - hold_q > step) ? hold_q + step : avg_hi; // R4
        else if (hold_q > avg_hi) hold_q <= (hold_q - avg_hi > step) ? hold_q - step : avg_hi;
      end
    end
  end

  // Holdover stays crystal-referenced; nothing here watches for drift into free-run.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_q <= FREQ_CENTRE;
      bwo_q <= BW_SYNTH;
      trk_q <= 1'b0;
    end else begin
      freq_q <= (state_q == ST_LOCK) ? loop_freq_i :
                (state_q == ST_HOLD) ? hold_q : FREQ_CENTRE; // R9 R10
      bwo_q <= synth_on ? BW_SYNTH : bw_sel; // R11 R13 R14
      trk_q <= state_q == ST_LOCK && !soft_q[ref_sel]; // R2 R20
    end
  end
  assign freq_ctl_o = freq_q;
  assign bw_code_o = bwo_q;
  assign track_en_o = trk_q;
  assign holdover_o = state_q == ST_HOLD; // R8
  assign stat_w = {19'h0, synth_on, bwo_q, ref_sel, soft_q, loss_q,
                   state_q == ST_LOCK && lock_det_i, hseen_q, holdover_o};
  assign hf_w = {avg_hi, hold_q};

  // Integer output divider; new settings take effect only at a sync trigger.
  logic [2:0] r1_q, c1_q;
  logic [16:0] h2_q, c2_q;
  logic q_q;
  wire p1 = c1_q == r1_q - 3'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r1_q <= 3'h4;
      h2_q <= 17'h0;
      c1_q <= 3'h0;
      c2_q <= 17'h0;
      q_q <= 1'b0;
    end else if (sync_q) begin
      r1_q <= ratio1(div_q[1:0]); // R16 R18
      h2_q <= div_q[18:2]; // R17
      c1_q <= 3'h0;
      c2_q <= 17'h0;
      q_q <= 1'b0;
    end else begin
      c1_q <= p1 ? 3'h0 : c1_q + 3'h1; // R15
      if (h2_q == 17'h0) q_q <= c1_q < (r1_q >> 1); // R17
      else if (p1) begin
        if (c2_q == h2_q - 17'h1) begin
          c2_q <= 17'h0;
          q_q <= ~q_q; // R15 R17
        end else c2_q <= c2_q + 17'h1;
      end
    end
  end
  assign integer_output_o = q_q;

  sequence s_lose_all;
    state_q == ST_LOCK && !any_valid && !synth_on;
  endsequence
  sequence s_enter_hold(logic [1:0] m);
    hold_enter && hmode == m;
  endsequence
  a_hold_entry: assert property (s_lose_all |=> holdover_o && hseen_q) // R3 R8
    else $error("loss of all inputs did not enter holdover");
  a_gap_hold: assert property (gap_en && hold_enter |-> &loss_q) // R1
    else $error("gapped holdover entered before signal loss");
  a_relock: assert property (state_q == ST_HOLD && any_valid && !synth_on |=> !holdover_o) // R22
    else $error("valid input did not leave holdover");
  a_hold_inst: assert property (s_enter_hold(HM_INST) |=> hold_q == $past(hist_old)) // R6
    else $error("instantaneous holdover value wrong");
  a_hold_fast: assert property (s_enter_hold(HM_FAST) |=> hold_q == $past(loop_freq_i)) // R4
    else $error("fast average did not hold last offset");
  a_hold_centre: assert property (s_enter_hold(HM_CENTRE) |=> ##1 freq_ctl_o == FREQ_CENTRE) // R5
    else $error("centre holdover value wrong");
  a_bw_synth: assert property (synth_on |=> bw_code_o == BW_SYNTH) // R11
    else $error("synthesizer bandwidth not fixed");
  a_bw_locked: assert property (!synth_on && !acq_en // R14
                                |=> bw_code_o == bw_clamp($past(bw_q[7:4])))
    else $error("locked bandwidth not applied");
  a_bw_acq: assert property (!synth_on && acq_en && !lock_det_i // R13
                             |=> bw_code_o == bw_clamp($past(bw_q[3:0])))
    else $error("acquisition bandwidth not applied");
  a_div_sync: assert property (sync_q |=> !integer_output_o ##1 c1_q == 3'h1) // R18
    else $error("sync did not restart the divider");
endmodule : dphb_core
`default_nettype wire

// ---- logic/dphb_pkg.sv ----
// Purpose: Shared constants and types for the holdover, bandwidth and divider block.
// Assumes: 25 MHz core clock and a classic Wishbone slave with 32-bit data.
// Notes: Register offsets are byte addresses of aligned words.
`default_nettype none
package dphb_pkg;
  localparam longint CLK_HZ = 25_000_000;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_BW = 8'h04;
  localparam logic [7:0] ADR_MON = 8'h08;
  localparam logic [7:0] ADR_DIV = 8'h0C;
  localparam logic [7:0] ADR_STAT = 8'h10;
  localparam logic [7:0] ADR_HFREQ = 8'h14;
  localparam logic [31:0] CTRL_MASK = 32'h0000_037F;
  localparam logic [31:0] BW_MASK = 32'h0000_00FF;
  localparam logic [31:0] MON_MASK = 32'h0001_FFFF;
  localparam logic [31:0] DIV_MASK = 32'h0007_FFFF;
  localparam logic [31:0] MON_RST = 32'h0000_0010;
  localparam int C_SYNTH = 0;
  localparam int C_STATE = 1;
  localparam int C_ACQ = 3;
  localparam int C_HMODE = 4;
  localparam int C_GAP = 6;
  localparam int C_SYNC = 7;
  localparam int C_SLEW = 8;
  localparam int S_HSEEN = 1;
  localparam logic [1:0] STATE_FREERUN = 2'h3;
  localparam logic [1:0] HM_CENTRE = 2'h0;
  localparam logic [1:0] HM_INST = 2'h1;
  localparam logic [1:0] HM_FAST = 2'h2;
  localparam logic [3:0] BW_MAX = 4'hE;
  localparam logic [3:0] BW_SYNTH = 4'hF;
  localparam int MON_DIV = 8;
  localparam logic [2:0] VALID_LAST = 3'h7;
  localparam int FW = 16;
  localparam logic [FW-1:0] FREQ_CENTRE = 16'h8000;
  localparam int HIST_MS = 100;
  localparam int HIST_DEPTH = 4;
  localparam int HIST_STEP_CYC = int'(HIST_MS * CLK_HZ / 1000 / HIST_DEPTH);
  localparam int IIR_MIN = 20;
  localparam int IIR_SHIFT = 16;
  localparam int IIR_STEP_CYC =
    int'(longint'(IIR_MIN) * 60 * CLK_HZ * 1000 / (6283 * (longint'(1) << IIR_SHIFT)));
  localparam int SLEW_STEP_CYC = 256;
  typedef enum logic [1:0] {ST_FREE, ST_LOCK, ST_HOLD} dphb_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dphb_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } dphb_wb_rsp_t;
endpackage : dphb_pkg
`default_nettype wire
